// ---- rtl/dso_fault_latch.sv ----
// dso_fault_latch: holds a detected fault and its code until a valid clear, a scale fault until reset
`timescale 1ns/1ns
module dso_fault_latch
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic fault_detect,
   input wire logic scale_fault,
   input wire logic [2:0] fault_code_in,
   input wire logic clear_req,
   output logic fault_held,
   output logic scale_held,
   output logic [2:0] fault_code,
   output logic set_pulse,
   output logic clear_pulse
);
   import dso_pkg::*;

   dso_fault_state_type state;
   dso_fault_state_type next_state;
   logic [2:0] next_fault_code;
   logic next_set_pulse;
   logic next_clear_pulse;

   // ****************************************************************
   // next state: latch on detect, release only on a clear with cause gone
   // ****************************************************************
   always_comb
   begin
      next_state = state;
      next_fault_code = fault_code;
      next_set_pulse = 1'b0;
      next_clear_pulse = 1'b0;
      unique case (state)
         FLT_NORMAL:
         begin
            if (fault_detect)
            begin
               next_state = scale_fault ? FLT_SCALE : FLT_HELD;
               next_fault_code = fault_code_in;
               next_set_pulse = 1'b1;
            end
         end
         FLT_HELD:
         begin
            if (fault_detect && scale_fault)
               next_state = FLT_SCALE;
            else if (clear_req && !fault_detect)
            begin
               next_state = FLT_NORMAL;
               next_fault_code = CODE_NONE;
               next_clear_pulse = 1'b1;
            end
         end
         FLT_SCALE:
         begin
            next_state = FLT_SCALE;
         end
      endcase
   end

   // state registers
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         state <= FLT_NORMAL;
         fault_code <= CODE_NONE;
         set_pulse <= 1'b0;
         clear_pulse <= 1'b0;
      end
      else
      begin
         state <= next_state;
         fault_code <= next_fault_code;
         set_pulse <= next_set_pulse;
         clear_pulse <= next_clear_pulse;
      end
   end

   assign fault_held = (state != FLT_NORMAL);
   assign scale_held = (state == FLT_SCALE);
endmodule // dso_fault_latch

// ---- rtl/dso_pkg.sv ----
// dso_pkg: constants shared by the drive status output block
package dso_pkg;
   // ****************************************************************
   // register byte offsets
   // ****************************************************************
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_THRESH = 8'h04;
   localparam logic [7:0] ADDR_ALLOC = 8'h08;
   localparam logic [7:0] ADDR_STATE = 8'h0C;
   localparam logic [7:0] ADDR_EVENT = 8'h10;
   localparam logic [7:0] ADDR_MASK = 8'h14;

   // ****************************************************************
   // field positions
   // ****************************************************************
   localparam int CTRL_SEL_BIT = 0;        // pending code output select
   localparam int CTRL_APPLY_BIT = 1;      // write 1: apply the select bit to the code output
   localparam int ALLOC_CAUTION_LSB = 0;   // 2-bit terminal number, 0 = none
   localparam int ALLOC_MOTION_LSB = 2;
   localparam int ALLOC_READY_LSB = 4;
   localparam int ST_FAULT_BIT = 0;
   localparam int ST_CODE_LSB = 1;
   localparam int ST_WARN_BIT = 4;
   localparam int ST_MOTION_BIT = 5;
   localparam int ST_READY_BIT = 6;
   localparam int ST_SCALE_BIT = 7;
   localparam int ST_SEL_BIT = 8;
   localparam int EV_FAULT_BIT = 0;        // fault latched
   localparam int EV_CLEAR_BIT = 1;        // fault cleared
   localparam int EV_WARN_BIT = 2;         // warning appeared
   localparam int EV_READY_BIT = 3;        // drive-ready changed

   // ****************************************************************
   // widths, limits and reset values
   // ****************************************************************
   localparam int SPEED_W = 14;
   localparam int EV_W = 4;
   localparam int ALLOC_W = 2;
   localparam logic [13:0] THRESH_MIN = 14'd1;
   localparam logic [13:0] THRESH_MAX = 14'd10000;
   localparam logic [13:0] THRESH_RST = 14'd20;
   localparam logic [1:0] ALLOC_CAUTION_RST = 2'h0;
   localparam logic [1:0] ALLOC_MOTION_RST = 2'h1;
   localparam logic [1:0] ALLOC_READY_RST = 2'h2;
   localparam logic CODE_SEL_FAULT_ONLY = 1'b0;
   localparam logic CODE_SEL_BOTH = 1'b1;
   localparam logic [2:0] CODE_NONE = 3'h0;

   // fault holding states, gray along normal -> fault -> scale
   typedef enum logic [1:0]
   {
      FLT_NORMAL = 2'b00,
      FLT_HELD = 2'b01,
      FLT_SCALE = 2'b11
   } dso_fault_state_type;
endpackage

// ---- rtl/dso_status_outputs.sv ----
// dso_status_outputs: fault, code, caution, motion and ready outputs of a drive
`timescale 1ns/1ns
module dso_status_outputs
#(
   parameter int NUM_TERM = 3
)
(
   input wire logic clk,
   input wire logic resetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   // drive conditions
   input wire logic fault_detect,
   input wire logic scale_fault,
   input wire logic [2:0] fault_code_in,
   input wire logic warning_active,
   input wire logic [2:0] warning_code_in,
   input wire logic [dso_pkg::SPEED_W-1:0] motor_speed,
   input wire logic main_power_on,
   input wire logic hardwired_power_block,
   input wire logic absolute_scale_used,
   input wire logic position_send_request,
   input wire logic absolute_data_sent,
   input wire logic hall_sensor_present,
   input wire logic polarity_done,
   input wire logic fault_clear_in,
   input wire logic key_up,
   input wire logic key_down,
   // pins
   output logic fault_out,
   output logic fault_code_bit_a,
   output logic fault_code_bit_b,
   output logic fault_code_bit_c,
   output logic motion_detect_out,
   output logic [NUM_TERM-1:0] terminal_out,
   output logic irq
);
   import dso_pkg::*;

   // clamp a threshold write into its legal range
   function automatic logic [SPEED_W-1:0] clamp_thresh(input logic [31:0] v);
      if (v < 32'(THRESH_MIN))
         clamp_thresh = THRESH_MIN;
      else if (v > 32'(THRESH_MAX))
         clamp_thresh = THRESH_MAX;
      else
         clamp_thresh = v[SPEED_W-1:0];
   endfunction

   // true when an allocation field names terminal t
   function automatic logic routed(input logic [ALLOC_W-1:0] a, input int t);
      routed = (a != '0) && (32'(a) == t + 1);
   endfunction

   // ****************************************************************
   // declarations
   // ****************************************************************
   logic [7:0] addr_q;
   logic wr_q;
   logic rd_q;
   logic [7:0] next_addr_q;
   logic next_wr_q;
   logic next_rd_q;
   logic next_hreadyout;
   logic [31:0] next_hrdata;
   logic code_sel_pend;
   logic code_sel_eff;
   logic [SPEED_W-1:0] motion_speed_threshold;
   logic [ALLOC_W-1:0] caution_terminal_alloc;
   logic [ALLOC_W-1:0] motion_terminal_alloc;
   logic [ALLOC_W-1:0] ready_terminal_alloc;
   logic [EV_W-1:0] mask;
   logic [EV_W-1:0] events;
   logic next_code_sel_pend;
   logic next_code_sel_eff;
   logic [SPEED_W-1:0] next_threshold;
   logic [ALLOC_W-1:0] next_caution_alloc;
   logic [ALLOC_W-1:0] next_motion_alloc;
   logic [ALLOC_W-1:0] next_ready_alloc;
   logic [EV_W-1:0] next_mask;
   logic [EV_W-1:0] next_events;
   logic [EV_W-1:0] ev_set;
   logic clear_in_q;
   logic keys_q;
   logic warn_q;
   logic ready_q;
   logic fault_held;
   logic scale_held;
   logic [2:0] held_code;
   logic fault_set_pulse;
   logic fault_clear_pulse;
   logic clear_req;
   logic keys_both;
   logic wr_go;
   logic rd_go;
   logic motion_now;
   logic ready_now;
   logic [2:0] code_now;
   logic [31:0] state_word;
   logic [NUM_TERM-1:0] next_terminal;

   // ****************************************************************
   // fault holding
   // ****************************************************************
   dso_fault_latch u_fault
   (
      .clk(clk),
      .resetn(resetn),
      .fault_detect(fault_detect),
      .scale_fault(scale_fault),
      .fault_code_in(fault_code_in),
      .clear_req(clear_req),
      .fault_held(fault_held),
      .scale_held(scale_held),
      .fault_code(held_code),
      .set_pulse(fault_set_pulse),
      .clear_pulse(fault_clear_pulse)
   );

   // clear requests on the rising edge of the input or of both keys held
   assign keys_both = key_up && key_down;
   assign clear_req = (fault_clear_in && !clear_in_q) || (keys_both && !keys_q);

   // ****************************************************************
   // status decode
   // ****************************************************************
   assign motion_now = (motor_speed >= motion_speed_threshold);
   assign ready_now = main_power_on && !hardwired_power_block && !fault_held
      && (!absolute_scale_used || (position_send_request && absolute_data_sent))
      && (hall_sensor_present || polarity_done);

   // code output: fault first, warning only when selected
   always_comb
   begin
      if (fault_held)
         code_now = held_code;
      else if (code_sel_eff == CODE_SEL_BOTH && warning_active)
         code_now = warning_code_in;
      else
         code_now = CODE_NONE;
   end

   always_comb
   begin
      state_word = '0;
      state_word[ST_FAULT_BIT] = fault_held;
      state_word[ST_CODE_LSB +: 3] = held_code;
      state_word[ST_WARN_BIT] = warning_active;
      state_word[ST_MOTION_BIT] = motion_now;
      state_word[ST_READY_BIT] = ready_now;
      state_word[ST_SCALE_BIT] = scale_held;
      state_word[ST_SEL_BIT] = code_sel_eff;
   end

   // ****************************************************************
   // ahb-lite slave: writes with no wait, reads with one wait state
   // ****************************************************************
   assign wr_go = wr_q;
   assign rd_go = rd_q && !hreadyout;

   always_comb
   begin
      next_addr_q = addr_q;
      next_wr_q = 1'b0;
      next_rd_q = 1'b0;
      next_hreadyout = 1'b1;
      next_hrdata = hrdata;
      if (rd_go)
      begin
         unique case (addr_q)
            ADDR_CTRL: next_hrdata = {31'h0000_0000, code_sel_pend};
            ADDR_THRESH: next_hrdata = {18'h0_0000, motion_speed_threshold};
            ADDR_ALLOC: next_hrdata = {26'h000_0000, ready_terminal_alloc, motion_terminal_alloc,
               caution_terminal_alloc};
            ADDR_STATE: next_hrdata = state_word;
            ADDR_EVENT: next_hrdata = {28'h000_0000, events};
            ADDR_MASK: next_hrdata = {28'h000_0000, mask};
            default: next_hrdata = 32'h0000_0000;
         endcase
      end
      else if (hsel && htrans[1] && hready && hreadyout)
      begin
         next_addr_q = haddr[7:0];
         next_wr_q = hwrite;
         next_rd_q = !hwrite;
         next_hreadyout = hwrite;
      end
      else if (rd_q)
         next_rd_q = 1'b0;
   end

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         addr_q <= 8'h00;
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         hreadyout <= 1'b1;
         hrdata <= 32'h0000_0000;
         hresp <= 1'b0;
      end
      else
      begin
         addr_q <= next_addr_q;
         wr_q <= next_wr_q;
         rd_q <= next_rd_q && !rd_go;
         hreadyout <= next_hreadyout;
         hrdata <= next_hrdata;
         hresp <= 1'b0;
      end
   end

   // ****************************************************************
   // configuration registers
   // ****************************************************************
   always_comb
   begin
      next_code_sel_pend = code_sel_pend;
      next_code_sel_eff = code_sel_eff;
      next_threshold = motion_speed_threshold;
      next_caution_alloc = caution_terminal_alloc;
      next_motion_alloc = motion_terminal_alloc;
      next_ready_alloc = ready_terminal_alloc;
      next_mask = mask;
      if (wr_go)
      begin
         unique case (addr_q)
            ADDR_CTRL:
            begin
               next_code_sel_pend = hwdata[CTRL_SEL_BIT];
               if (hwdata[CTRL_APPLY_BIT])
                  next_code_sel_eff = hwdata[CTRL_SEL_BIT];
            end
            ADDR_THRESH: next_threshold = clamp_thresh(hwdata);
            ADDR_ALLOC:
            begin
               next_caution_alloc = hwdata[ALLOC_CAUTION_LSB +: ALLOC_W];
               next_motion_alloc = hwdata[ALLOC_MOTION_LSB +: ALLOC_W];
               next_ready_alloc = hwdata[ALLOC_READY_LSB +: ALLOC_W];
            end
            ADDR_MASK: next_mask = hwdata[EV_W-1:0];
            default: next_mask = mask;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         code_sel_pend <= CODE_SEL_FAULT_ONLY;
         code_sel_eff <= CODE_SEL_FAULT_ONLY;
         motion_speed_threshold <= THRESH_RST;
         caution_terminal_alloc <= ALLOC_CAUTION_RST;
         motion_terminal_alloc <= ALLOC_MOTION_RST;
         ready_terminal_alloc <= ALLOC_READY_RST;
         mask <= '0;
      end
      else
      begin
         code_sel_pend <= next_code_sel_pend;
         code_sel_eff <= next_code_sel_eff;
         motion_speed_threshold <= next_threshold;
         caution_terminal_alloc <= next_caution_alloc;
         motion_terminal_alloc <= next_motion_alloc;
         ready_terminal_alloc <= next_ready_alloc;
         mask <= next_mask;
      end
   end

   // ****************************************************************
   // sticky events: a set in the clearing cycle wins
   // ****************************************************************
   always_comb
   begin
      ev_set = '0;
      ev_set[EV_FAULT_BIT] = fault_set_pulse;
      ev_set[EV_CLEAR_BIT] = fault_clear_pulse;
      ev_set[EV_WARN_BIT] = warning_active && !warn_q;
      ev_set[EV_READY_BIT] = ready_now != ready_q;
      next_events = events;
      if (wr_go && addr_q == ADDR_EVENT)
         next_events = events & ~hwdata[EV_W-1:0];
      next_events = next_events | ev_set;
   end

   // ****************************************************************
   // pin outputs and terminal routing
   // ****************************************************************
   always_comb
   begin
      for (int t = 0; t < NUM_TERM; t++)
      begin
         next_terminal[t] = (routed(caution_terminal_alloc, t) && warning_active)
            || (routed(motion_terminal_alloc, t) && motion_now)
            || (routed(ready_terminal_alloc, t) && ready_now);
      end
   end

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         events <= '0;
         clear_in_q <= 1'b0;
         keys_q <= 1'b0;
         warn_q <= 1'b0;
         ready_q <= 1'b0;
         irq <= 1'b0;
         fault_out <= 1'b0;
         fault_code_bit_a <= 1'b0;
         fault_code_bit_b <= 1'b0;
         fault_code_bit_c <= 1'b0;
         motion_detect_out <= 1'b0;
         terminal_out <= '0;
      end
      else
      begin
         events <= next_events;
         clear_in_q <= fault_clear_in;
         keys_q <= keys_both;
         warn_q <= warning_active;
         ready_q <= ready_now;
         irq <= |(next_events & mask);
         fault_out <= !fault_held;
         fault_code_bit_a <= code_now[0];
         fault_code_bit_b <= code_now[1];
         fault_code_bit_c <= code_now[2];
         motion_detect_out <= motion_now;
         terminal_out <= next_terminal;
      end
   end
endmodule // dso_status_outputs

// ---- tb/dso_host_model.sv ----
// dso_host_model: host controller and main power cut-off around the drive
`timescale 1ns/1ns
module dso_host_model
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic fault_out,
   input wire logic power_switch,
   input wire logic send_enable,
   input wire logic [5:0] send_delay,
   output logic main_power_on,
   output logic position_send_request,
   output logic absolute_data_sent
);
   logic [5:0] count;
   logic [5:0] next_count;
   // contactor drops main power as soon as the fault contact opens
   assign main_power_on = power_switch & fault_out;
   assign position_send_request = send_enable;
   // absolute data reported done a programmable time after the request
   always_comb next_count = (!resetn || !send_enable) ? 6'h00 : (count < send_delay ? count + 6'h01 : count);
   always_ff @(posedge clk) count <= next_count;
   assign absolute_data_sent = send_enable && (count >= send_delay);
endmodule // dso_host_model

// ---- tb/dso_status_outputs_assertions.sv ----
// dso_status_outputs_assertions: timing checks on the status outputs
`timescale 1ns/1ns
module dso_status_outputs_assertions
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic fault_detect,
   input wire logic scale_fault,
   input wire logic [2:0] fault_code_in,
   input wire logic fault_clear_in,
   input wire logic key_up,
   input wire logic key_down,
   input wire logic [dso_pkg::SPEED_W-1:0] motor_speed,
   input wire logic fault_out,
   input wire logic fault_code_bit_a,
   input wire logic fault_code_bit_b,
   input wire logic fault_code_bit_c,
   input wire logic motion_detect_out
);
   logic scale_seen;
   logic next_scale_seen;
   logic [2:0] code;
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   assign code = {fault_code_bit_c, fault_code_bit_b, fault_code_bit_a};
   // remember a scale fault until control power is cycled
   always_comb next_scale_seen = resetn & (scale_seen | (fault_detect & scale_fault));
   always_ff @(posedge clk) scale_seen <= next_scale_seen;

   chk_fault_opens:
      assert property ($past(resetn, 2) && fault_detect |-> ##[2:3] !fault_out) else $error("fault not shown");
   chk_fault_stays:
      assert property ($past(resetn, 6) ##0 (!fault_out && !fault_clear_in && !key_up) [*4] |=> !fault_out)
      else $error("fault dropped without clear");
   chk_code_latch:
      assert property ($past(resetn, 3) && $fell(fault_out) |-> code == $past(fault_code_in, 2))
      else $error("wrong fault code");
   chk_code_hold:
      assert property ($past(resetn, 3) && !fault_out && $past(!fault_out) |-> $stable(code))
      else $error("held code moved");
   chk_clear_input:
      assert property ($past(resetn, 3) && !fault_out && !scale_seen && !fault_detect && $rose(fault_clear_in)
         ##1 !fault_detect [*3] |-> fault_out) else $error("clear input ignored");
   chk_key_clear:
      assert property ($past(resetn, 3) && !fault_out && !scale_seen && !fault_detect && $rose(key_up && key_down)
         |-> ##[1:3] fault_out) else $error("panel clear ignored");
   chk_scale_stuck:
      assert property (scale_seen && !fault_out |=> !fault_out) else $error("scale fault cleared");
   chk_motion_max:
      assert property ($past(resetn, 2) && $past(motor_speed) >= 14'h2710 |-> motion_detect_out)
      else $error("motion missed at top speed");
   chk_motion_zero:
      assert property ($past(resetn, 2) && $past(motor_speed) == 14'h0000 |-> !motion_detect_out)
      else $error("motion shown at standstill");
endmodule // dso_status_outputs_assertions

bind dso_status_outputs dso_status_outputs_assertions chk (.clk, .resetn, .fault_detect, .scale_fault,
   .fault_code_in, .fault_clear_in, .key_up, .key_down, .motor_speed, .fault_out, .fault_code_bit_a,
   .fault_code_bit_b, .fault_code_bit_c, .motion_detect_out);

// ---- tb/dso_status_outputs_bench.sv ----
// dso_status_outputs_bench: self-checking bench for the drive status outputs
`timescale 1ns/1ns
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
   $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module dso_status_outputs_bench;
   import dso_pkg::*;
   logic clk, resetn, hsel, hwrite, hready, hreadyout, hresp, irq;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize, fault_code_in, warning_code_in, terminal_out;
   logic [SPEED_W-1:0] motor_speed;
   logic fault_detect, scale_fault, warning_active, main_power_on, hardwired_power_block;
   logic absolute_scale_used, position_send_request, absolute_data_sent, hall_sensor_present, polarity_done;
   logic fault_clear_in, key_up, key_down, fault_out, fault_code_bit_a, fault_code_bit_b, fault_code_bit_c;
   logic motion_detect_out, power_switch, send_enable;
   logic [5:0] send_delay;
   int error_cnt, tests_run, cycles;
   assign hready = hreadyout;
   dso_status_outputs dut (.*);
   dso_host_model host (.clk, .resetn, .fault_out, .power_switch, .send_enable, .send_delay, .main_power_on,
      .position_send_request, .absolute_data_sent);
   // free-running clock
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // hang guard
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         error_cnt++;
         print_verdict();
      end
   end
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk);
   endtask
   // one ahb-lite single word transfer, read data left in rd
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd);
      hsel <= 1'b1;
      haddr <= 32'(a);
      htrans <= 2'b10;
      hwrite <= w;
      do @(posedge clk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge clk); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
      bus(a, 1'b0, 32'h0000_0000);
      `CHK(nm, e, rd)
   endtask
   task automatic rst();
      resetn <= 1'b0;
      step(6);
      resetn <= 1'b1;
      step(3);
   endtask
   task automatic fault(input logic [2:0] c);
      fault_code_in <= c;
      step(1);
      fault_detect <= 1'b1;
      step(2);
      fault_detect <= 1'b0;
      step(4);
   endtask
   task automatic clr();
      fault_clear_in <= 1'b1;
      step(4);
      fault_clear_in <= 1'b0;
      step(1);
   endtask
   function automatic logic [2:0] code();
      return {fault_code_bit_c, fault_code_bit_b, fault_code_bit_a};
   endfunction
   task automatic t_reset();
      rchk("thresh", ADDR_THRESH, 32'h0000_0014);
      rchk("alloc", ADDR_ALLOC, 32'h0000_0024);
      rchk("mask", ADDR_MASK, 32'h0000_0000);
      rchk("unmapped", 8'h20, 32'h0000_0000);
      `CHK("okay response", 1'b0, hresp)
      `CHK("fault idle", 1'b1, fault_out)
      `CHK("ready idle", 3'b010, terminal_out)
   endtask
   task automatic t_fault();
      bus(ADDR_EVENT, 1'b1, 32'h0000_000F);
      bus(ADDR_MASK, 1'b1, 32'h0000_000F);
      fault_code_in <= 3'h5;
      step(1);
      fault_detect <= 1'b1;
      fault_clear_in <= 1'b1;
      step(3);
      fault_detect <= 1'b0;
      fault_clear_in <= 1'b0;
      step(4);
      `CHK("fault open", 1'b0, fault_out)
      `CHK("code", 3'h5, code())
      `CHK("irq", 1'b1, irq)
      `CHK("ready in fault", 1'b0, terminal_out[1])
      fault_code_in <= 3'h1;
      step(3);
      `CHK("code kept", 3'h5, code())
      clr();
      `CHK("cleared", 1'b1, fault_out)
      `CHK("code gone", 3'h0, code())
      rchk("events", ADDR_EVENT, 32'h0000_000B);
      bus(ADDR_EVENT, 1'b1, 32'h0000_000F);
      step(2);
      `CHK("irq off", 1'b0, irq)
      bus(ADDR_MASK, 1'b1, 32'h0000_0000);
   endtask
   task automatic t_keys();
      fault(3'h2);
      key_up <= 1'b1;
      step(4);
      `CHK("one key", 1'b0, fault_out)
      key_down <= 1'b1;
      step(4);
      `CHK("two keys", 1'b1, fault_out)
      key_up <= 1'b0;
      key_down <= 1'b0;
   endtask
   task automatic t_warn();
      warning_code_in <= 3'h3;
      warning_active <= 1'b1;
      step(3);
      `CHK("caution unallocated", 3'b010, terminal_out)
      `CHK("fault only", 3'h0, code())
      bus(ADDR_ALLOC, 1'b1, 32'h0000_0027);
      step(2);
      `CHK("caution on", 3'b110, terminal_out)
      bus(ADDR_CTRL, 1'b1, 32'h0000_0001);
      step(2);
      `CHK("pending select", 3'h0, code())
      bus(ADDR_CTRL, 1'b1, 32'h0000_0003);
      step(2);
      `CHK("warning code", 3'h3, code())
      fault(3'h6);
      `CHK("fault wins", 3'h6, code())
      clr();
      warning_active <= 1'b0;
      step(3);
      `CHK("caution off", 3'b010, terminal_out)
      bus(ADDR_CTRL, 1'b1, 32'h0000_0002);
      bus(ADDR_ALLOC, 1'b1, 32'h0000_0024);
   endtask
   task automatic t_motion();
      motor_speed <= 14'h0013;
      step(3);
      `CHK("below", 1'b0, motion_detect_out)
      motor_speed <= 14'h0014;
      step(3);
      `CHK("at threshold", 1'b1, motion_detect_out)
      bus(ADDR_THRESH, 1'b1, 32'h0000_0000);
      rchk("low clamp", ADDR_THRESH, 32'h0000_0001);
      bus(ADDR_THRESH, 1'b1, 32'h0000_3FFF);
      rchk("high clamp", ADDR_THRESH, 32'h0000_2710);
      motor_speed <= 14'h270F;
      step(3);
      `CHK("under max", 1'b0, motion_detect_out)
      motor_speed <= 14'h2710;
      step(3);
      `CHK("at max", 1'b1, motion_detect_out)
      bus(ADDR_THRESH, 1'b1, 32'h0000_0064);
      motor_speed <= 14'h0032;
      step(3);
      `CHK("new threshold", 1'b0, motion_detect_out)
      bus(ADDR_ALLOC, 1'b1, 32'h0000_002C);
      motor_speed <= 14'h00C8;
      step(3);
      `CHK("moved terminal", 3'b110, terminal_out)
      bus(ADDR_ALLOC, 1'b1, 32'h0000_0024);
      bus(ADDR_THRESH, 1'b1, 32'h0000_0014);
      motor_speed <= 14'h0000;
   endtask
   task automatic t_ready();
      for (int i = 0; i < 4; i++)
      begin
         power_switch <= (i != 0);
         hardwired_power_block <= (i == 1);
         absolute_scale_used <= (i == 2);
         hall_sensor_present <= (i != 3);
         step(4);
         `CHK("ready blocked", 1'b0, terminal_out[1])
      end
      send_delay <= 6'h14;
      send_enable <= 1'b1;
      absolute_scale_used <= 1'b1;
      polarity_done <= 1'b1;
      step(6);
      `CHK("data pending", 1'b0, terminal_out[1])
      step(20);
      `CHK("data sent", 1'b1, terminal_out[1])
      bus(ADDR_ALLOC, 1'b1, 32'h0000_0014);
      step(2);
      `CHK("ready moved", 3'b001, terminal_out)
      bus(ADDR_ALLOC, 1'b1, 32'h0000_0024);
   endtask
   task automatic t_scale();
      scale_fault <= 1'b1;
      fault(3'h7);
      clr();
      key_up <= 1'b1;
      key_down <= 1'b1;
      step(4);
      `CHK("scale held", 1'b0, fault_out)
      rchk("state", ADDR_STATE, 32'h0000_008F);
      key_up <= 1'b0;
      key_down <= 1'b0;
      scale_fault <= 1'b0;
      rst();
      `CHK("scale after reset", 1'b1, fault_out)
   endtask
   // main sequence
   initial
   begin
      {hsel, hwrite, resetn, fault_detect, scale_fault, warning_active, hardwired_power_block} = '0;
      {absolute_scale_used, polarity_done, fault_clear_in, key_up, key_down, send_enable} = '0;
      {haddr, hwdata, htrans, fault_code_in, warning_code_in, motor_speed} = '0;
      hsize = 3'b010;
      hall_sensor_present = 1'b1;
      power_switch = 1'b1;
      send_delay = 6'h02;
      rst();
      t_reset();
      t_fault();
      t_keys();
      t_warn();
      t_motion();
      t_ready();
      t_scale();
      print_verdict();
   end
endmodule // dso_status_outputs_bench
